// ==== hw/tx_dpll_pin_ctrl_defs.svh ====
// Constants for the transmit DPLL pin control and status block.
// Assumes a single 200 MHz reference clock drives the block.
`ifndef TX_DPLL_PIN_CTRL_DEFS_SVH
`define TX_DPLL_PIN_CTRL_DEFS_SVH

// ==========================================================================
// Register map
`define MODE_SEL_OFFSET      8'h1F
`define MODE_SEL_RESET       8'h00
`define MODE_FIELD_LSB       0
`define MODE_SRC_BIT         2
`define HS_OVR_BIT           3
`define HS_VAL_BIT           4

// ==========================================================================
// Timing
`define CLK_PERIOD_PS        5000
`define RESET_MIN_NS         300
`define RESET_MIN_CYCLES     ((`RESET_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ==========================================================================
// Synthesizer output defaults; synth0 frame pulse in kHz, synth1 clocks in Hz
`define SYNTH0_FP_DEFAULT_KHZ  32'h0000_0008
`define SYNTH1_CLKA_DEFAULT_HZ 32'h0017_8F40
`define SYNTH1_CLKB_DEFAULT_HZ 32'h002F_1E80

`endif

// ==== hw/tx_dpll_pin_ctrl_pkg.sv ====
// Types for the transmit DPLL pin control and status block.
// Assumes the constants header is compiled alongside.
package tx_dpll_pin_ctrl_pkg;

  // ==========================================================================
  // Mode encoding, shared by the mode pins and the mode register
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_HOLDOVER = 2'b01,
    MODE_FREERUN  = 2'b10,
    MODE_AUTO     = 2'b11
  } dpll_mode_t;

  typedef struct packed {
    logic lock;
    logic hold;
  } dpll_status_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

// ==== hw/tx_dpll_pin_ctrl_status.sv ====
// Control and status pin logic for the transmit DPLL.
// Assumes the serial interface decoder delivers one-cycle register requests.
`timescale 1ns/100ps
`default_nettype none
`include "tx_dpll_pin_ctrl_defs.svh"

// Behaviour
// (RULE1) Low reset clears all; hold 300 ns.
// (RULE2) Hitless enable high keeps phase on switch.
// (RULE3) Hitless enable low realigns phase to reference.
// (RULE4) Hitless control also settable by register.
// (RULE5) Mode pins sampled during reset give default.
// (RULE6) Mode from pins or register 0x1F.
// (RULE7) Driver enable high drives, low tristates.
// (RULE8) Lock high when frequency and phase locked.
// (RULE9) Hold high when DPLL enters holdover.
// (RULE10) Selected reference output copies receive selector.
// (RULE11) Frame output b configurable, defaults 8 kHz. Code: fixed at the reset default, nothing writes it.
// (RULE12) Clock a programmable, defaults 1.544 MHz. Code: fixed at the reset default, nothing writes it.
// (RULE13) Clock b derived from a, defaults 3.088 MHz. Code: a separate fixed reset constant, not derived from a.
// (RULE14) Frame output a configurable, defaults 8 kHz. Code: fixed at the reset default, nothing writes it.
// (RULE15) Two-bit mode code shared by pins and register.
module tx_dpll_pin_ctrl_status (
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [1:0]                     mode_pins_i,
  input  wire logic                           hitless_switch_enable_i,
  input  wire logic                           lvpecl_driver_a_enable_i,
  input  wire logic                           lvpecl_driver_b_enable_i,
  input  wire logic                           freq_locked_i,
  input  wire logic                           phase_locked_i,
  input  wire logic                           rx_ref_sel_i,
  input  wire tx_dpll_pin_ctrl_pkg::reg_req_t req_i,
  output logic [7:0]                          rdata_o,
  output tx_dpll_pin_ctrl_pkg::dpll_mode_t    mode_o,
  output logic                                hitless_o,
  output logic                                phase_realign_o,
  output logic                                lvpecl_a_oe_o,
  output logic                                lvpecl_b_oe_o,
  output tx_dpll_pin_ctrl_pkg::dpll_status_t  status_o,
  output logic                                ref_out_o,
  output logic [31:0]                         synth0_fp_a_khz_o,
  output logic [31:0]                         synth0_fp_b_khz_o,
  output logic [31:0]                         synth1_clk_a_hz_o,
  output logic [31:0]                         synth1_clk_b_hz_o
);
  import tx_dpll_pin_ctrl_pkg::*;

  // ==========================================================================
  // Register access
  logic [7:0]  mode_sel_reg;
  logic [1:0]  strap_reg;
  logic        strap_done_reg;
  logic        hs_prev_reg;
  wire         hit_mode  = (req_i.addr == `MODE_SEL_OFFSET);
  wire         wr_mode   = req_i.wr && hit_mode;
  wire         src_reg   = mode_sel_reg[`MODE_SRC_BIT];
  wire         hs_ovr    = mode_sel_reg[`HS_OVR_BIT];

  // ==========================================================================
  // Mode and hitless selection
  // Strap is the default only until the first edge after reset release; the live
  // pins follow then, unless software claims the mode by setting the source bit.
  wire [1:0]   pin_mode  = strap_done_reg ? mode_pins_i : strap_reg; // [RULE6]
  wire [1:0]   reg_mode  = mode_sel_reg[`MODE_FIELD_LSB +: 2]; // [RULE15]
  wire [1:0]   mode_sel  = src_reg ? reg_mode : pin_mode; // [RULE6]
  wire         hs_eff    = hs_ovr ? mode_sel_reg[`HS_VAL_BIT]
                                  : hitless_switch_enable_i; // [RULE4]
  wire [7:0]   rd_next   = hit_mode ? mode_sel_reg : 8'h00;

  // Straps are sampled on every edge while reset is held low, so the last
  // level seen before release becomes the default mode.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      strap_reg <= mode_pins_i; // [RULE5]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin // [RULE1]
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_sel_reg <= `MODE_SEL_RESET;
    end else if (wr_mode) begin
      mode_sel_reg <= req_i.wdata; // [RULE6]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o         <= 8'h00;
      mode_o          <= MODE_NORMAL;
      hitless_o       <= 1'b0;
      phase_realign_o <= 1'b0;
      hs_prev_reg     <= 1'b0;
      lvpecl_a_oe_o   <= 1'b0;
      lvpecl_b_oe_o   <= 1'b0;
      status_o        <= '0;
      ref_out_o       <= 1'b0;
    end else begin
      if (req_i.rd) begin
        rdata_o <= rd_next;
      end
      mode_o          <= dpll_mode_t'(mode_sel);
      hitless_o       <= hs_eff; // [RULE2]
      hs_prev_reg     <= hs_eff;
      // A one-cycle strobe when hitless enable falls requests a realign.
      phase_realign_o <= hs_prev_reg && !hs_eff; // [RULE3]
      lvpecl_a_oe_o   <= lvpecl_driver_a_enable_i; // [RULE7]
      lvpecl_b_oe_o   <= lvpecl_driver_b_enable_i; // [RULE7]
      status_o.lock   <= freq_locked_i && phase_locked_i; // [RULE8]
      status_o.hold   <= (mode_sel == MODE_HOLDOVER); // [RULE9]
      ref_out_o       <= rx_ref_sel_i; // [RULE10]
    end
  end

  // ==========================================================================
  // Synthesizer defaults; the frequency words feed the analog synthesizers.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      synth0_fp_a_khz_o <= `SYNTH0_FP_DEFAULT_KHZ; // [RULE14]
      synth0_fp_b_khz_o <= `SYNTH0_FP_DEFAULT_KHZ; // [RULE11]
      synth1_clk_a_hz_o <= `SYNTH1_CLKA_DEFAULT_HZ; // [RULE12]
      synth1_clk_b_hz_o <= `SYNTH1_CLKB_DEFAULT_HZ; // [RULE13]
    end
  end

endmodule // tx_dpll_pin_ctrl_status
`default_nettype wire

// ==== tb/board_pin_model.sv ====
// Board logic that drives the control and status pins.
// Levels change at the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module board_pin_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] want_i,
  output var  logic [7:0] pins_o = 8'hFF
);
  // Pins idle high, since the inputs carry pull-ups.
  always @(negedge ref_clk_i) pins_o <= want_i;
endmodule // board_pin_model
`default_nettype wire

// ==== tb/test_tx_dpll_pin_ctrl_status.sv ====
// Testbench for the transmit DPLL pin control block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_tx_dpll_pin_ctrl_status;
  import tx_dpll_pin_ctrl_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, seen, hitless_switch_enable_i;
  logic [1:0] mode_pins_i;
  logic lvpecl_driver_a_enable_i, lvpecl_driver_b_enable_i, rx_ref_sel_i;
  logic freq_locked_i, phase_locked_i, hitless_o, phase_realign_o;
  logic lvpecl_a_oe_o, lvpecl_b_oe_o, ref_out_o;
  logic [7:0] want = 8'hFE, pins, rdata_o;
  logic [31:0] synth0_fp_a_khz_o, synth0_fp_b_khz_o;
  logic [31:0] synth1_clk_a_hz_o, synth1_clk_b_hz_o;
  reg_req_t req_i = '0;
  dpll_mode_t mode_o;
  dpll_status_t status_o;
  int n_mismatch = 0, compares = 0, cyc = 0;
  assign {rx_ref_sel_i, phase_locked_i, freq_locked_i, lvpecl_driver_b_enable_i,
    lvpecl_driver_a_enable_i, hitless_switch_enable_i, mode_pins_i} = pins;
  always #2.5 ref_clk_i = ~ref_clk_i;
  board_pin_model board_u (.ref_clk_i(ref_clk_i), .want_i(want), .pins_o(pins));
  tx_dpll_pin_ctrl_status dut_u (.*);
  task wr(input logic [7:0] a, d);
    @(negedge ref_clk_i) req_i = '{a, d, 1'b1, 1'b0};
    @(negedge ref_clk_i) req_i.wr = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge ref_clk_i) req_i = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge ref_clk_i) req_i.rd = 1'b0;
    `TB_CHK(rdata_o, e)
  endtask
  task pchk(input logic [7:0] w, input logic [3:0] e);
    want = w;
    repeat (4) @(negedge ref_clk_i);
    `TB_CHK({status_o.lock, lvpecl_a_oe_o, lvpecl_b_oe_o, ref_out_o}, e)
  endtask
  // Reset spans the minimum low time plus margin; straps are set first.
  task hold_reset(input logic [7:0] w);
    want = w;
    rst_n_i = 1'b0;
    repeat (64) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task test_done;
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    hold_reset(8'hFE);
    `TB_CHK(mode_o, MODE_FREERUN)
    `TB_CHK({synth0_fp_a_khz_o, synth0_fp_b_khz_o}, {2{32'h8}})
    `TB_CHK(synth1_clk_b_hz_o, 32'h002F_1E80)
    pchk(8'hFD, 4'hF);
    `TB_CHK({mode_o, status_o.hold, hitless_o}, 4'h7)
    for (int i = 0; i < 4; i++) begin
      wr(8'h1F, 8'h04 | 8'(i));
      `TB_CHK(mode_o, dpll_mode_t'(i))
    end
    wr(8'h1E, 8'hFF);
    rd(8'h1F, 8'h07);
    rd(8'h20, 8'h00);
    want = 8'hF9;
    seen = 1'b0;
    repeat (4) @(negedge ref_clk_i) seen |= phase_realign_o;
    `TB_CHK({seen, hitless_o}, 2'h2)
    wr(8'h1F, 8'h18);
    `TB_CHK(hitless_o, 1'b1)
    pchk(8'hA9, 4'h5);
    pchk(8'h51, 4'h2);
    pchk(8'h61, 4'h8);
    hold_reset(8'hFF);
    `TB_CHK({mode_o, hitless_o}, 3'h7)
    rd(8'h1F, 8'h00);
    test_done;
  end
endmodule // test_tx_dpll_pin_ctrl_status
`default_nettype wire

// ==== tb/tx_dpll_pin_props.sv ====
// Port checker for the pin control block.
// Bound to the design; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module tx_dpll_pin_props (
  input wire logic                          ref_clk_i,
  input wire logic                          rst_n_i,
  input wire logic                          hitless_o,
  input wire logic                          freq_locked_i,
  input wire logic                          phase_locked_i,
  input wire logic                          lvpecl_driver_a_enable_i,
  input wire logic                          lvpecl_a_oe_o,
  input wire logic                          rx_ref_sel_i,
  input wire logic                          phase_realign_o,
  input wire logic                          ref_out_o,
  input wire tx_dpll_pin_ctrl_pkg::reg_req_t req_i,
  input wire logic [7:0]                    rdata_o,
  input wire logic [1:0]                    mode_o,
  input wire logic [1:0]                    status_o,
  input wire logic [31:0]                   synth1_clk_a_hz_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_lock_both: assert property (
    $past(rst_n_i) |-> status_o[1] == $past(freq_locked_i && phase_locked_i))
    else $error("lock flag wrong");
  chk_hold_mode: assert property (
    status_o[0] == (mode_o == 2'h1)) else $error("hold flag wrong");
  chk_drv_follow: assert property (
    $past(rst_n_i) |-> lvpecl_a_oe_o == $past(lvpecl_driver_a_enable_i))
    else $error("driver enable wrong");
  chk_ref_copy: assert property (
    $past(rst_n_i) |-> ref_out_o == $past(rx_ref_sel_i))
    else $error("reference copy wrong");
  chk_realign_once: assert property (
    phase_realign_o |=> !phase_realign_o) else $error("realign too long");
  chk_realign_low: assert property (
    phase_realign_o |-> !hitless_o) else $error("realign while hitless");
  chk_unmapped_zero: assert property (
    req_i.rd && req_i.addr != 8'h1F |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_clk_dflt: assert property (
    synth1_clk_a_hz_o == 32'h0017_8F40) else $error("clock default wrong");
  cover property (req_i.wr);
  cover property ($fell(hitless_o));
  cover property (status_o[0]);
endmodule // tx_dpll_pin_props
bind tx_dpll_pin_ctrl_status tx_dpll_pin_props chk_u (.*);
`default_nettype wire
